// ==== pfs_pkg.sv ====
// Shared constants and types for the port 6/7/8 function selector.
package pfs_pkg;

	// Register bus geometry.
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 8;

	// Register offsets.
	localparam logic [4:0] OFS_LCD_CTRL0  = 5'h00; // Segment select SEG0..3, backplane select lines 0..3.
	localparam logic [4:0] OFS_LCD_CTRL1  = 5'h01; // Segment select SEG4..11.
	localparam logic [4:0] OFS_BP_SEL     = 5'h02; // Backplane select lines 4..7 in bits 7:4.
	localparam logic [4:0] OFS_INT_EN     = 5'h03; // External interrupt input enables 0..7.
	localparam logic [4:0] OFS_INT_GSEL   = 5'h04; // External interrupt group selects 0..7.
	localparam logic [4:0] OFS_KEY_EN     = 5'h05; // Key input enables 0..7.
	localparam logic [4:0] OFS_KEY_GSEL   = 5'h06; // Key group selects 0..7.
	localparam logic [4:0] OFS_SER_MODE1  = 5'h07; // Serial 0 rx, tx, shared I/O, clock pin enables.
	localparam logic [4:0] OFS_SER_MODE3  = 5'h08; // Serial 0 chip-select enable.
	localparam logic [4:0] OFS_SER_PSEL   = 5'h09; // Serial 0 rx, tx, clock, chip-select group selects.
	localparam logic [4:0] OFS_TM_OEN     = 5'h0a; // Timer 3 and timer 5 output enables.
	localparam logic [4:0] OFS_TM_CKSRC   = 5'h0b; // Timer 3 clock source [1:0], timer 5 [3:2].
	localparam logic [4:0] OFS_TM_GSEL    = 5'h0c; // Timer 3 and timer 5 I/O group selects.
	localparam logic [4:0] OFS_ANA_EN     = 5'h0d; // Analog enables for port 8 pins 0..5.
	localparam logic [4:0] OFS_STAT_P6    = 5'h0e; // Read only: port 6 pins in a special function.
	localparam logic [4:0] OFS_STAT_P7    = 5'h0f; // Read only: port 7 pins in a special function.
	localparam logic [4:0] OFS_STAT_P8    = 5'h10; // Read only: port 8 pins in a special function.

	// Field positions inside the serial and timer registers.
	localparam int unsigned SER_RX_EN_BIT  = 0;
	localparam int unsigned SER_TX_EN_BIT  = 1;
	localparam int unsigned SER_IOM_BIT    = 2;
	localparam int unsigned SER_CLK_EN_BIT = 3;
	localparam int unsigned SER_CS_EN_BIT  = 0;
	localparam int unsigned SER_RX_GS_BIT  = 0;
	localparam int unsigned SER_TX_GS_BIT  = 1;
	localparam int unsigned SER_CLK_GS_BIT = 2;
	localparam int unsigned SER_CS_GS_BIT  = 3;
	localparam int unsigned TM3_BIT        = 0;
	localparam int unsigned TM5_BIT        = 1;

	// Values after reset and special codes.
	localparam logic [7:0] REG_RST      = 8'h00;
	localparam logic [1:0] CK_FROM_PIN  = 2'h3; // Timer counts its own pin, so the pin is an input.
	localparam int unsigned NPIN        = 22;   // Port 6 at 0..7, port 7 at 8..15, port 8 at 16..21.

	// What a pin does this cycle.
	typedef enum logic [2:0]
	{
		FN_NONE = 3'h0, // Undriven, no input route.
		FN_PORT = 3'h1, // Plain port I/O.
		FN_LCD  = 3'h2, // LCD segment or backplane drive.
		FN_OUT  = 3'h3, // Peripheral output, always driven.
		FN_IN   = 3'h4, // Peripheral input only.
		FN_DIO  = 3'h5, // Peripheral pin whose drive follows the port direction bit.
		FN_ANA  = 3'h6  // Analog or oscillator pin.
	} pfs_fn_t;

endpackage

// ==== pfs_pin_cell.sv ====
// One pad cell: input synchroniser and registered drive for a single pin.
`timescale 1ns/1ps

module pfs_pin_cell
	import pfs_pkg::*;
(
	input  wire logic    clk,      // Core clock.
	input  wire logic    rstn,     // Asynchronous reset, active low.
	input  wire logic    ce,       // Clock enable; state freezes while low.
	input  wire pfs_fn_t fn,       // Selected function of the pin.
	input  wire logic    port_o,   // Port data latch value.
	input  wire logic    port_dir, // Port direction bit, 1 drives.
	input  wire logic    lcd_lvl,  // LCD drive level for this pin.
	input  wire logic    per_o,    // Peripheral output level.
	input  wire logic    pin_i,    // Raw pad input.
	output logic         pin_o,    // Registered pad output level.
	output logic         pin_oe,   // Registered pad output enable.
	output logic         pin_ana,  // Registered analog mode flag.
	output logic         route_in, // Registered peripheral input route.
	output logic         pin_rd    // Synchronised pad level for port reads.
);

	logic sync1_reg; // First synchroniser stage, read only by the second.
	logic o_next;    // Next pad output level.
	logic oe_next;   // Next pad output enable.
	logic in_next;   // Next peripheral input route.

	// Drive and route decode; unmatched settings leave the pin quiet. [R17]
	assign o_next  = (fn == FN_PORT) ? port_o :
	                 (fn == FN_LCD)  ? lcd_lvl :
	                 (fn == FN_OUT || fn == FN_DIO) ? per_o : 1'b0;
	assign oe_next = (fn == FN_PORT || fn == FN_DIO) ? port_dir :
	                 (fn == FN_LCD || fn == FN_OUT);
	// Input routes only open on peripheral pins, so idle peripherals see a steady low. [R17]
	assign in_next = (fn == FN_IN || fn == FN_DIO) ? pin_rd : 1'b0;

	// Two-stage synchroniser for the pad input.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync1_reg <= 1'b0;
			pin_rd    <= 1'b0;
		end
		else if (ce)
		begin
			sync1_reg <= pin_i;
			pin_rd    <= sync1_reg;
		end
	end

	// Registered outputs so the pad never sees decode glitches.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_o    <= 1'b0;
			pin_oe   <= 1'b0;
			pin_ana  <= 1'b0;
			route_in <= 1'b0;
		end
		else if (ce)
		begin
			pin_o    <= o_next;
			pin_oe   <= oe_next;
			pin_ana  <= (fn == FN_ANA);
			route_in <= in_next;
		end
	end

endmodule

// ==== pfs_top.sv ====
// Function selector for ports 6, 7 and 8 with its configuration registers.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Function
// R1: P60/P61: segment, else group-B interrupt, else port.
// R2: P62/P63: interrupt only when enabled and selected.
// R3: P64: LCD, key, serial receive, port.
// R4: P65: key before serial transmit, then port.
// R5: Software sets direction bit for transmit.
// R6: Shared data pin needs receive and I/O mode.
// R7: P66: key, else serial clock, else port.
// R8: Software sets direction bit when clock master.
// R9: P67: key, else chip select, else port.
// R10: P70/P71: backplane, segment, interrupt, port; the pin goes LCD on segment select only, backplane picks the level.
// R11: P72: LCD, interrupt 4, timer 3 I/O.
// R12: P73: LCD, else timer 5 I/O, else port.
// R13: P74..P77: backplane select or plain port.
// R14: P80/P81: oscillator, else group-A interrupt.
// R15: P82..P85: analog enable or plain port.
// R16: Segment availability is a per-variant parameter.
// R17: Unmatched settings leave pin undriven and quiet.
module pfs_top
	import pfs_pkg::*;
#(
	parameter logic [11:0] SEG_AVAIL = 12'hfff, // Segment lines present on this variant.
	parameter logic [7:0]  COM_AVAIL = 8'hff    // Backplane lines present on this variant.
)
(
	input  wire logic        CLK,       // Core clock, 200 MHz.
	input  wire logic        RSTN,      // Asynchronous reset, active low.
	input  wire logic        CE,        // Clock enable; all state freezes while low.
	input  wire logic [4:0]  ADDR,      // Register address.
	input  wire logic [7:0]  WDATA,     // Register write data.
	input  wire logic        WR,        // Write strobe.
	input  wire logic        RD,        // Read strobe.
	output logic      [7:0]  RDATA,     // Read data, valid the cycle after RD.
	input  wire logic [7:0]  P6_DATA,   // Port 6 data latch.
	input  wire logic [7:0]  P6_DIR,    // Port 6 direction bits.
	input  wire logic [7:0]  P7_DATA,   // Port 7 data latch.
	input  wire logic [7:0]  P7_DIR,    // Port 7 direction bits.
	input  wire logic [5:0]  P8_DATA,   // Port 8 data latch.
	input  wire logic [5:0]  P8_DIR,    // Port 8 direction bits.
	input  wire logic [7:0]  P6_I,      // Port 6 pad inputs.
	input  wire logic [7:0]  P7_I,      // Port 7 pad inputs.
	input  wire logic [5:0]  P8_I,      // Port 8 pad inputs.
	output logic      [7:0]  P6_O,      // Port 6 pad outputs.
	output logic      [7:0]  P6_OE,     // Port 6 pad output enables.
	output logic      [7:0]  P7_O,      // Port 7 pad outputs.
	output logic      [7:0]  P7_OE,     // Port 7 pad output enables.
	output logic      [5:0]  P8_O,      // Port 8 pad outputs.
	output logic      [5:0]  P8_OE,     // Port 8 pad output enables.
	output logic      [5:0]  P8_ANA,    // Port 8 pins handed to analog use.
	output logic      [7:0]  P6_RD,     // Synchronised port 6 levels.
	output logic      [7:0]  P7_RD,     // Synchronised port 7 levels.
	output logic      [5:0]  P8_RD,     // Synchronised port 8 levels.
	input  wire logic [11:0] LCD_SEG,   // Segment drive levels from the LCD block.
	input  wire logic [7:0]  LCD_COM,   // Backplane drive levels from the LCD block.
	input  wire logic        SER0_TX_O, // Serial 0 transmit data.
	input  wire logic        SER0_CK_O, // Serial 0 clock when master.
	input  wire logic        SER0_CS_O, // Serial 0 chip select when driving.
	input  wire logic        TM3_O,     // Timer 3 output.
	input  wire logic        TM5_O,     // Timer 5 output.
	output logic      [6:0]  INT_B,     // Group-B interrupt inputs 0..6.
	output logic      [1:0]  INT_A,     // Group-A interrupt inputs 2 and 3.
	output logic      [3:0]  KEY_B,     // Key inputs 4..7, group B.
	output logic             SER0_RX_I, // Serial 0 receive data.
	output logic             SER0_CK_I, // Serial 0 clock input.
	output logic             SER0_CS_I, // Serial 0 chip-select input.
	output logic             TM3_I,     // Timer 3 pin input.
	output logic             TM5_I      // Timer 5 pin input.
);

	// Configuration registers, all written by software.
	logic [7:0] lcd_pin_ctrl_reg_0;          // [3:0] SEG0..3 select, [7:4] backplane lines 0..3.
	logic [7:0] lcd_pin_ctrl_reg_1;          // SEG4..11 select.
	logic [7:0] lcd_backplane_select_reg;    // [7:4] backplane lines 4..7.
	logic [7:0] ext_int_input_enable_reg;    // Interrupt input enables.
	logic [7:0] ext_int_group_select_reg;    // Interrupt group selects, 1 picks group B.
	logic [7:0] keypad_input_enable_reg;     // Key input enables.
	logic [7:0] keypad_group_select_reg;     // Key group selects.
	logic [7:0] serial0_mode_reg_1;          // Serial 0 pin enables.
	logic [7:0] serial0_mode_reg_3;          // Serial 0 chip-select enable.
	logic [7:0] serial01_pin_select_reg;     // Serial 0 group selects, 0 picks group A.
	logic [7:0] timer_io_out_enable_reg;     // Timer output enables.
	logic [7:0] timer_clk_src_reg;           // Timer clock sources.
	logic [7:0] timer_io_group_select_reg;   // Timer I/O group selects.
	logic [7:0] analog_pin_enable_reg_1;     // Port 8 analog enables.
	logic [7:0] rdata_next;                  // Read mux output.

	// Effective LCD selects, trimmed to what this variant bonds out. [R16]
	wire [11:0] seg_sel = {lcd_pin_ctrl_reg_1, lcd_pin_ctrl_reg_0[3:0]} & SEG_AVAIL;
	wire [7:0]  com_sel = {lcd_backplane_select_reg[7:4], lcd_pin_ctrl_reg_0[7:4]} & COM_AVAIL;

	// Named control bits.
	wire [7:0] int_en   = ext_int_input_enable_reg;
	wire [7:0] int_gs   = ext_int_group_select_reg;
	wire [7:0] key_on   = keypad_input_enable_reg & keypad_group_select_reg;
	wire       rx_en    = serial0_mode_reg_1[SER_RX_EN_BIT];
	wire       tx_en    = serial0_mode_reg_1[SER_TX_EN_BIT];
	wire       io_mode  = serial0_mode_reg_1[SER_IOM_BIT];
	wire       ck_en    = serial0_mode_reg_1[SER_CLK_EN_BIT];
	wire       cs_en    = serial0_mode_reg_3[SER_CS_EN_BIT];
	wire [3:0] ser_gs   = serial01_pin_select_reg[3:0];
	wire       t3_sel   = timer_io_group_select_reg[TM3_BIT];
	wire       t5_sel   = timer_io_group_select_reg[TM5_BIT];
	wire       t3_oe    = timer_io_out_enable_reg[TM3_BIT];
	wire       t5_oe    = timer_io_out_enable_reg[TM5_BIT];
	wire       t3_pin   = (timer_clk_src_reg[1:0] == CK_FROM_PIN);
	wire       t5_pin   = (timer_clk_src_reg[3:2] == CK_FROM_PIN);
	wire [5:0] ana_en   = analog_pin_enable_reg_1[5:0];

	// Serial group-A pin requests.
	wire ser_rx_a = rx_en & ~io_mode & ~ser_gs[SER_RX_GS_BIT];           // [R3]
	wire ser_tx_a = (tx_en | (rx_en & io_mode)) & ~ser_gs[SER_TX_GS_BIT]; // [R4] [R6]
	wire ser_ck_a = ck_en & ~ser_gs[SER_CLK_GS_BIT];                       // [R7]
	wire ser_cs_a = cs_en & ~ser_gs[SER_CS_GS_BIT];                        // [R9]

	// Flattened per-pin function, LCD level and peripheral level.
	pfs_fn_t      fn [NPIN];
	wire [NPIN-1:0] lcd_lvl;
	wire [NPIN-1:0] per_o;
	wire [NPIN-1:0] port_o   = {P8_DATA, P7_DATA, P6_DATA};
	wire [NPIN-1:0] port_dir = {P8_DIR, P7_DIR, P6_DIR};
	wire [NPIN-1:0] pin_i    = {P8_I, P7_I, P6_I};
	wire [NPIN-1:0] pin_o;
	wire [NPIN-1:0] pin_oe;
	wire [NPIN-1:0] pin_ana;
	wire [NPIN-1:0] route_in;
	wire [NPIN-1:0] pin_rd;

	// Port 6 pins 0,1: segment, then group-B interrupt, else port. [R1]
	assign fn[0] = seg_sel[11] ? FN_LCD : (int_en[0] & int_gs[0]) ? FN_IN : FN_PORT;
	assign fn[1] = seg_sel[10] ? FN_LCD : (int_en[1] & int_gs[1]) ? FN_IN : FN_PORT;
	// Port 6 pins 2,3: no port fallback, the pin is left quiet instead. [R2]
	assign fn[2] = seg_sel[9] ? FN_LCD : (int_en[2] & int_gs[2]) ? FN_IN : FN_NONE;
	assign fn[3] = seg_sel[8] ? FN_LCD : (int_en[3] & int_gs[3]) ? FN_IN : FN_NONE;
	// Port 6 pin 4: LCD, key, serial receive, port. [R3]
	assign fn[4] = seg_sel[7] ? FN_LCD : key_on[4] ? FN_IN : ser_rx_a ? FN_IN : FN_PORT;
	// Port 6 pin 5: the key path beats serial transmit; drive follows direction bit. [R4] [R5]
	assign fn[5] = seg_sel[6] ? FN_LCD : key_on[5] ? FN_IN : ser_tx_a ? FN_DIO : FN_PORT;
	// Port 6 pin 6: clock pin drives only when software makes it an output. [R7] [R8]
	assign fn[6] = seg_sel[5] ? FN_LCD : key_on[6] ? FN_IN : ser_ck_a ? FN_DIO : FN_PORT;
	// Port 6 pin 7: chip select, driven under the direction bit. [R9]
	assign fn[7] = seg_sel[4] ? FN_LCD : key_on[7] ? FN_IN : ser_cs_a ? FN_DIO : FN_PORT;

	// Port 7 pins 0,1: segment select, with backplane over segment on the level, then group-B interrupt 6 or 5. [R10]
	assign fn[8]  = seg_sel[3] ? FN_LCD : (int_en[6] & int_gs[6]) ? FN_IN : FN_PORT;
	assign fn[9]  = seg_sel[2] ? FN_LCD : (int_en[5] & int_gs[5]) ? FN_IN : FN_PORT;
	// Port 7 pin 2: LCD, interrupt 4 group B, timer 3 I/O, port. [R11]
	assign fn[10] = seg_sel[1] ? FN_LCD :
	                (int_en[4] & int_gs[4]) ? FN_IN :
	                (t3_sel & t3_pin) ? FN_IN :
	                (t3_sel & t3_oe) ? FN_OUT : FN_PORT;
	// Port 7 pin 3: LCD, timer 5 I/O, port. [R12]
	assign fn[11] = seg_sel[0] ? FN_LCD :
	                (t5_sel & t5_pin) ? FN_IN :
	                (t5_sel & t5_oe) ? FN_OUT : FN_PORT;

	// Port 7 pins 4..7 and port 8 pins 2..5 repeat one pattern each.
	genvar g;
	generate
		for (g = 4; g < 8; g++)
		begin : g_p7_com
			// One backplane select bit per pin, backplane line 7-g. [R13]
			assign fn[8+g] = com_sel[7-g] ? FN_LCD : FN_PORT;
		end
		for (g = 2; g < 6; g++)
		begin : g_p8_ana
			// Pump capacitor and bias pins follow their analog enable. [R15]
			assign fn[16+g] = ana_en[g] ? FN_ANA : FN_PORT;
		end
	endgenerate

	// Port 8 pins 0,1: oscillator, then group-A interrupt 2 or 3, else quiet. [R14]
	assign fn[16] = ana_en[0] ? FN_ANA : (int_en[2] & ~int_gs[2]) ? FN_IN : FN_NONE;
	assign fn[17] = ana_en[1] ? FN_ANA : (int_en[3] & ~int_gs[3]) ? FN_IN : FN_NONE;

	// LCD levels: port 6 carries SEG11..4; port 7 low pins pick backplane over segment. [R10]
	assign lcd_lvl[7:0]   = {LCD_SEG[4], LCD_SEG[5], LCD_SEG[6], LCD_SEG[7],
	                         LCD_SEG[8], LCD_SEG[9], LCD_SEG[10], LCD_SEG[11]};
	assign lcd_lvl[8]     = com_sel[7] ? LCD_COM[7] : LCD_SEG[3];
	assign lcd_lvl[9]     = com_sel[6] ? LCD_COM[6] : LCD_SEG[2];
	assign lcd_lvl[10]    = com_sel[5] ? LCD_COM[5] : LCD_SEG[1];
	assign lcd_lvl[11]    = com_sel[4] ? LCD_COM[4] : LCD_SEG[0];
	assign lcd_lvl[15:12] = {LCD_COM[0], LCD_COM[1], LCD_COM[2], LCD_COM[3]};
	assign lcd_lvl[21:16] = 6'h00;

	// Peripheral output levels; only pins with an output function use theirs.
	assign per_o = {10'h000, TM5_O, TM3_O, 1'b0, 1'b0, SER0_CS_O, SER0_CK_O, SER0_TX_O, 5'h00};

	// One pad cell per pin.
	generate
		for (g = 0; g < NPIN; g++)
		begin : g_cell
			pfs_pin_cell u_cell
			(
				.clk      (CLK),
				.rstn     (RSTN),
				.ce       (CE),
				.fn       (fn[g]),
				.port_o   (port_o[g]),
				.port_dir (port_dir[g]),
				.lcd_lvl  (lcd_lvl[g]),
				.per_o    (per_o[g]),
				.pin_i    (pin_i[g]),
				.pin_o    (pin_o[g]),
				.pin_oe   (pin_oe[g]),
				.pin_ana  (pin_ana[g]),
				.route_in (route_in[g]),
				.pin_rd   (pin_rd[g])
			);
		end
	endgenerate

	// Pad outputs come straight from the cell flip-flops.
	assign {P8_O, P7_O, P6_O}    = pin_o;
	assign {P8_OE, P7_OE, P6_OE} = pin_oe;
	assign {P8_RD, P7_RD, P6_RD} = pin_rd;
	assign P8_ANA                = pin_ana[21:16];

	// Peripheral inputs: each is one cell's registered route, so idle paths stay low.
	// Pin 10 also carries the timer 3 input, so interrupt 4 only opens when it owns the pin. [R11]
	assign INT_B     = {route_in[8], route_in[9], route_in[10] & int_en[4] & int_gs[4], route_in[3:0]};
	assign INT_A     = route_in[17:16];
	// Pins 4..7 share a route between key and serial; only the active function opens. [R3]
	assign KEY_B     = route_in[7:4] & key_on[7:4];
	assign SER0_RX_I = route_in[4] & ~key_on[4];
	assign SER0_CK_I = route_in[6] & ~key_on[6];
	assign SER0_CS_I = route_in[7] & ~key_on[7];
	assign TM3_I     = route_in[10] & ~(int_en[4] & int_gs[4]);
	assign TM5_I     = route_in[11];

	// Status: which pins are currently not in plain port mode, quiet unrouted pins included.
	wire [NPIN-1:0] spec;
	generate
		for (g = 0; g < NPIN; g++)
		begin : g_stat
			assign spec[g] = (fn[g] != FN_PORT);
		end
	endgenerate

	// Register write port; a write to an unmapped or read-only address is dropped.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			lcd_pin_ctrl_reg_0        <= REG_RST;
			lcd_pin_ctrl_reg_1        <= REG_RST;
			lcd_backplane_select_reg  <= REG_RST;
			ext_int_input_enable_reg  <= REG_RST;
			ext_int_group_select_reg  <= REG_RST;
			keypad_input_enable_reg   <= REG_RST;
			keypad_group_select_reg   <= REG_RST;
			serial0_mode_reg_1        <= REG_RST;
			serial0_mode_reg_3        <= REG_RST;
			serial01_pin_select_reg   <= REG_RST;
			timer_io_out_enable_reg   <= REG_RST;
			timer_clk_src_reg         <= REG_RST;
			timer_io_group_select_reg <= REG_RST;
			analog_pin_enable_reg_1   <= REG_RST;
		end
		else if (CE && WR)
		begin
			unique case (ADDR)
				OFS_LCD_CTRL0: lcd_pin_ctrl_reg_0        <= WDATA;
				OFS_LCD_CTRL1: lcd_pin_ctrl_reg_1        <= WDATA;
				OFS_BP_SEL:    lcd_backplane_select_reg  <= {WDATA[7:4], 4'h0};
				OFS_INT_EN:    ext_int_input_enable_reg  <= WDATA;
				OFS_INT_GSEL:  ext_int_group_select_reg  <= WDATA;
				OFS_KEY_EN:    keypad_input_enable_reg   <= WDATA;
				OFS_KEY_GSEL:  keypad_group_select_reg   <= WDATA;
				OFS_SER_MODE1: serial0_mode_reg_1        <= {4'h0, WDATA[3:0]};
				OFS_SER_MODE3: serial0_mode_reg_3        <= {7'h00, WDATA[0]};
				OFS_SER_PSEL:  serial01_pin_select_reg   <= {4'h0, WDATA[3:0]};
				OFS_TM_OEN:    timer_io_out_enable_reg   <= {6'h00, WDATA[1:0]};
				OFS_TM_CKSRC:  timer_clk_src_reg         <= {4'h0, WDATA[3:0]};
				OFS_TM_GSEL:   timer_io_group_select_reg <= {6'h00, WDATA[1:0]};
				OFS_ANA_EN:    analog_pin_enable_reg_1   <= {2'h0, WDATA[5:0]};
				default:       ;
			endcase
		end
	end

	// Read mux; unmapped addresses answer zero.
	always_comb
	begin
		unique case (ADDR)
			OFS_LCD_CTRL0: rdata_next = lcd_pin_ctrl_reg_0;
			OFS_LCD_CTRL1: rdata_next = lcd_pin_ctrl_reg_1;
			OFS_BP_SEL:    rdata_next = lcd_backplane_select_reg;
			OFS_INT_EN:    rdata_next = ext_int_input_enable_reg;
			OFS_INT_GSEL:  rdata_next = ext_int_group_select_reg;
			OFS_KEY_EN:    rdata_next = keypad_input_enable_reg;
			OFS_KEY_GSEL:  rdata_next = keypad_group_select_reg;
			OFS_SER_MODE1: rdata_next = serial0_mode_reg_1;
			OFS_SER_MODE3: rdata_next = serial0_mode_reg_3;
			OFS_SER_PSEL:  rdata_next = serial01_pin_select_reg;
			OFS_TM_OEN:    rdata_next = timer_io_out_enable_reg;
			OFS_TM_CKSRC:  rdata_next = timer_clk_src_reg;
			OFS_TM_GSEL:   rdata_next = timer_io_group_select_reg;
			OFS_ANA_EN:    rdata_next = analog_pin_enable_reg_1;
			OFS_STAT_P6:   rdata_next = spec[7:0];
			OFS_STAT_P7:   rdata_next = spec[15:8];
			OFS_STAT_P8:   rdata_next = {2'h0, spec[21:16]};
			default:       rdata_next = 8'h00;
		endcase
	end

	// Read data stands for the one cycle after the strobe, zero otherwise.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			RDATA <= 8'h00;
		else if (CE)
			RDATA <= RD ? rdata_next : 8'h00;
	end

endmodule

// ==== pfs_top_assertions.sv ====
// Assertions tying pin drive to shadowed configuration.
`timescale 1ns/1ps
module pfs_chk
	import pfs_pkg::*;
(
	input wire logic       CLK,     // Core clock.
	input wire logic       RSTN,    // Reset, active low.
	input wire logic [4:0] ADDR,    // Bus address.
	input wire logic [7:0] WDATA,   // Bus write data.
	input wire logic       WR,      // Write strobe.
	input wire logic [7:0] P6_OE,   // Port 6 enables.
	input wire logic [7:0] P7_O,    // Port 7 levels.
	input wire logic [7:0] P7_OE,   // Port 7 enables.
	input wire logic [7:0] P7_DIR,  // Port 7 directions.
	input wire logic [5:0] P8_OE,   // Port 8 enables.
	input wire logic [5:0] P8_ANA,  // Port 8 analog flags.
	input wire logic [5:0] P8_DIR,  // Port 8 directions.
	input wire logic [7:0] LCD_COM, // Backplane levels.
	input wire logic [6:0] INT_B,   // Group-B interrupts.
	input wire logic [1:0] INT_A    // Group-A interrupts.
);
	logic [7:0] lc0_reg, lc1_reg, ien_reg, gs_reg, an_reg; // Shadows of five registers.
	// Shadows follow the bus; the bench holds clock enable high.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			{lc0_reg, lc1_reg, ien_reg, gs_reg, an_reg} <= '0;
		else if (WR)
		begin
			if (ADDR == OFS_LCD_CTRL0) lc0_reg <= WDATA;
			if (ADDR == OFS_LCD_CTRL1) lc1_reg <= WDATA;
			if (ADDR == OFS_INT_EN) ien_reg <= WDATA;
			if (ADDR == OFS_INT_GSEL) gs_reg <= WDATA;
			if (ADDR == OFS_ANA_EN) an_reg <= WDATA;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// Pads lag the configuration by one edge.
	a_ana_undriven: assert property ((P8_ANA & P8_OE) == 6'h00)
		else $error("Analog pin driven.");
	a_bp_drive: assert property (lc0_reg[4] |=> P7_OE[7] && P7_O[7] == $past(LCD_COM[0]))
		else $error("Backplane not on pin.");
	a_bp_port: assert property (!lc0_reg[4] |=> P7_OE[7] == $past(P7_DIR[7]))
		else $error("Port ignores direction.");
	a_pump_pin: assert property (an_reg[2] |=> P8_ANA[2] && !P8_OE[2])
		else $error("Pump pin not analog.");
	a_pump_port: assert property (!an_reg[3] |=> !P8_ANA[3] && P8_OE[3] == $past(P8_DIR[3]))
		else $error("Pin not plain port.");
	a_osc_quiet: assert property (!an_reg[0] && !(ien_reg[2] && !gs_reg[2]) |=>
		!P8_OE[0] && !P8_ANA[0] && !INT_A[0])
		else $error("Idle crystal pin active.");
	a_irq_input: assert property (!lc1_reg[7] && ien_reg[0] && gs_reg[0] |=> !P6_OE[0])
		else $error("Interrupt pin driven.");
	a_irq_idle: assert property (!lc1_reg[5] && !(ien_reg[2] && gs_reg[2]) |=> !P6_OE[2] && !INT_B[2])
		else $error("Idle pin active.");
	c_bp: cover property (lc0_reg[4] && P7_OE[7]);
	c_pump: cover property (P8_ANA[2]);
	c_irq: cover property (ien_reg[0] && gs_reg[0] && !P6_OE[0]);
endmodule

bind pfs_top pfs_chk u_chk (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .P6_OE(P6_OE),
	.P7_O(P7_O), .P7_OE(P7_OE), .P7_DIR(P7_DIR), .P8_OE(P8_OE), .P8_ANA(P8_ANA), .P8_DIR(P8_DIR),
	.LCD_COM(LCD_COM), .INT_B(INT_B), .INT_A(INT_A));

// ==== pfs_pads.sv ====
// Pad-side model of the outside world for ports 6, 7 and 8.
`timescale 1ns/1ps
module pfs_pads
(
	input  wire logic [21:0] o,    // Pad output levels.
	input  wire logic [21:0] oe,   // Pad output enables.
	input  wire logic [21:0] ext,  // Level the outside source sets.
	output logic      [21:0] pin_i // Level seen at the pads.
);
	// A released pin shows the outside source, never its stale drive.
	assign pin_i = (o & oe) | (ext & ~oe);
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the port 6/7/8 function selector.
`timescale 1ns/1ps
module tb_top;
	import pfs_pkg::*;
	// Pad vectors pack port 6, 7, 8 from bit 0.
	logic        CLK, RSTN, WR, RD;
	logic [4:0]  ADDR, per, pin_in;
	logic [7:0]  WDATA, RDATA, LCD_COM;
	logic [11:0] LCD_SEG;
	logic [21:0] pd, pdir, po, poe, ext, pi; // Latch, direction, out, enable, outside, in.
	logic [6:0]  INT_B;
	logic [5:0]  P8_ANA;
	logic [3:0]  KEY_B;
	logic [1:0]  INT_A;
	int          fail_count, samples_checked, cyc; // Mismatches, comparisons, cycles.
	pfs_top DUT (.CLK(CLK), .RSTN(RSTN), .CE(1'b1), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .P6_DATA(pd[7:0]), .P6_DIR(pdir[7:0]), .P7_DATA(pd[15:8]), .P7_DIR(pdir[15:8]),
		.P8_DATA(pd[21:16]), .P8_DIR(pdir[21:16]), .P6_I(pi[7:0]), .P7_I(pi[15:8]), .P8_I(pi[21:16]),
		.P6_O(po[7:0]), .P6_OE(poe[7:0]), .P7_O(po[15:8]), .P7_OE(poe[15:8]), .P8_O(po[21:16]),
		.P8_OE(poe[21:16]), .P8_ANA(P8_ANA), .P6_RD(), .P7_RD(), .P8_RD(), .LCD_SEG(LCD_SEG),
		.LCD_COM(LCD_COM), .SER0_TX_O(per[0]), .SER0_CK_O(per[1]), .SER0_CS_O(per[2]), .TM3_O(per[3]),
		.TM5_O(per[4]), .INT_B(INT_B), .INT_A(INT_A), .KEY_B(KEY_B), .SER0_RX_I(pin_in[0]),
		.SER0_CK_I(pin_in[1]), .SER0_CS_I(pin_in[2]), .TM3_I(pin_in[3]), .TM5_I(pin_in[4]));
	pfs_pads PADS (.o(po), .oe(poe), .ext(ext), .pin_i(pi));
	// Compare one packed result.
	task chk(input string n, input logic [15:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// One-cycle write strobe.
	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	// Read data stand one cycle after the strobe.
	task rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		@(negedge CLK);
		chk("rdata", {8'h00, e}, {8'h00, RDATA});
	endtask
	// Flip all sources, then wait out the input path.
	task lv(input logic x);
		@(posedge CLK);
		LCD_SEG <= {12{x}} ^ 12'h5a5;
		LCD_COM <= {8{x}} ^ 8'h3c;
		per <= {5{x}} ^ 5'h0a;
		ext <= {22{x}} ^ 22'h2aaaaa;
		repeat (4) @(posedge CLK);
		@(negedge CLK);
	endtask
	// Reset state, masked bits, read-only, hole; shared data pin.
	task t_regs();
		lv(1'b0);
		chk("p7port", {poe[15:8], po[15:8]}, {pdir[15:8], pd[15:8]});
		wr(OFS_SER_MODE1, 8'hff);
		rd(OFS_SER_MODE1, 8'h0f);
		wr(OFS_STAT_P7, 8'hff);
		rd(OFS_STAT_P7, 8'h00);
		rd(5'h1f, 8'h00);
		wr(OFS_SER_MODE1, 8'h05);
		lv(1'b1);
		chk("shared", {poe[5:4], po[5], pin_in[0]}, {2'b11, per[0], 1'b0});
	endtask
	// Segment, then group-B interrupts.
	task t_p6irq();
		wr(OFS_LCD_CTRL1, 8'h80);
		for (int x = 0; x < 2; x++)
		begin
			lv(x[0]);
			chk("seg11", {poe[0], po[0]}, {1'b1, LCD_SEG[11]});
		end
		wr(OFS_LCD_CTRL1, 8'h00);
		wr(OFS_INT_EN, 8'h05);
		wr(OFS_INT_GSEL, 8'h01);
		for (int x = 0; x < 2; x++)
		begin
			lv(x[0]);
			chk("irq", {INT_B[2], INT_B[0], poe[2], poe[0]}, {1'b0, ext[0], 2'b00});
		end
	endtask
	// Serial group A, then keys, on pins 4..7.
	task t_p6ser();
		wr(OFS_SER_MODE1, 8'h0b);
		wr(OFS_SER_MODE3, 8'h01);
		for (int x = 0; x < 2; x++)
		begin
			lv(x[0]);
			chk("ser", {po[7:5], poe[7:4], pin_in[0]}, {per[2:0], 4'he, ext[4]});
		end
		wr(OFS_KEY_EN, 8'hf0);
		wr(OFS_KEY_GSEL, 8'hf0);
		for (int x = 0; x < 2; x++)
		begin
			lv(x[0]);
			chk("key", {KEY_B, pin_in[0]}, {ext[7:4], 1'b0});
		end
	endtask
	// Port 7 LCD and timer pins.
	task t_p7();
		wr(OFS_LCD_CTRL0, 8'h1c);
		wr(OFS_BP_SEL, 8'h80);
		wr(OFS_TM_GSEL, 8'h03);
		wr(OFS_TM_OEN, 8'h01);
		wr(OFS_TM_CKSRC, 8'h0c);
		for (int x = 0; x < 2; x++)
		begin
			lv(x[0]);
			chk("p7", {po[15], po[10:8], poe[11], pin_in[4]},
				{LCD_COM[0], per[3], LCD_SEG[2], LCD_COM[7], 1'b0, ext[11]});
		end
	endtask
	// Port 8 analog pins, group-A interrupt.
	task t_p8();
		wr(OFS_ANA_EN, 8'h05);
		wr(OFS_INT_EN, 8'h08);
		for (int x = 0; x < 2; x++)
		begin
			lv(x[0]);
			chk("p8", {P8_ANA[3:0], poe[19:16], INT_A[1], po[19]}, {4'h5, 4'h8, ext[17], pd[19]});
		end
	endtask
	task final_report();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	// A hung wait still reaches the verdict.
	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			fail_count++;
			final_report();
		end
	end
	initial
	begin
		{RSTN, WR, RD, ADDR, WDATA, LCD_SEG, LCD_COM, per, ext} = '0;
		pd = 22'h1a5c96;
		pdir = 22'h3fffff; // Software drives every output pin.
		repeat (6) @(posedge CLK);
		RSTN <= 1'b1;
		t_regs();
		t_p6irq();
		t_p6ser();
		t_p7();
		t_p8();
		final_report();
	end
endmodule
